// *** rtl/addr_decoder_map.vh ***
// Address map, register layout and timing constants for the memory address decoder
`ifndef ADDR_DECODER_MAP_VH
`define ADDR_DECODER_MAP_VH

// CPU-side address map (byte addresses, 24 bits)
`define FLASH_LOW_BASE 24'h000000
`define FLASH_LOW_LAST 24'h007fff
`define FLASH_B4_BASE 24'h018000
`define FLASH_B4_LAST 24'h01ffff
`define FLASH_B5_BASE 24'h020000
`define FLASH_B5_LAST 24'h02ffff
`define TEST_FLASH_LAST 24'h001fff
`define RSV_FLASH_BASE 24'h030000
`define RSV_FLASH_LAST 24'h04ffff
`define RSV_IBUS_BASE 24'h050000
`define RSV_IBUS_LAST 24'h07ffff
`define RSV_IBUS_VALUE 16'h009b
`define DUAL_PORT_INTERNAL_RAM_BASE 24'h00f600
`define DUAL_PORT_INTERNAL_RAM_LAST 24'h00fdff
`define SFR_BASE 24'h00fe00
`define SFR_LAST 24'h00ffff
`define ESFR_BASE 24'h00f000
`define ESFR_LAST 24'h00f1ff
`define SMALL_RAM_BASE 24'h00e000
`define SMALL_RAM_LAST 24'h00e7ff
`define CAN1_BASE 24'h00ef00
`define CAN1_LAST 24'h00efff
`define CAN2_BASE 24'h00ee00
`define CAN2_LAST 24'h00eeff
`define LARGE_RAM_RESET_BASE 24'h090000

// Target codes
`define TGT_EXT 4'h0
`define TGT_FLASH 4'h1
`define TGT_TEST_FLASH 4'h2
`define TGT_DUAL_PORT_INTERNAL_RAM 4'h3
`define TGT_SMALL_RAM 4'h4
`define TGT_LARGE_RAM 4'h5
`define TGT_SFR 4'h6
`define TGT_CAN1 4'h7
`define TGT_CAN2 4'h8
`define TGT_RSV_IBUS 4'h9

// Config bit positions
`define SYSCFG_PERIPH_EN_BIT 2
`define PBCFG_CAN1_BIT 0
`define PBCFG_CAN2_BIT 1
`define PBCFG_SMALL_RAM_BIT 2
`define PBCFG_LARGE_RAM_BIT 3

// AXI4-Lite register byte offsets
`define REG_SYSTEM_CONFIG 12'h000
`define REG_PERIPH_BUS_CONFIG 12'h004
`define REG_LARGE_RAM_BASE 12'h008
`define REG_MODE 12'h00c
`define REG_STATUS 12'h010
`define REG_ACCESS_COUNT 12'h014

// Reset values
`define RST_SYSTEM_CONFIG 16'h0000
`define RST_PERIPH_BUS_CONFIG 16'h0000
`define RST_LARGE_RAM_BASE 16'h0009

// Wait states
`define WAIT_CAN 2'h2
`define WAIT_EXT_RAM 2'h0

`endif

// *** rtl/wait_timer.v ***
// Wait-state counter that completes an access after a given number of waits
`timescale 1ns/1ps
module wait_timer
(
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire start,
	input wire [1:0] waits,
	output reg done
);
	reg [1:0] remaining;
	reg busy;
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			remaining <= 2'h0;
			busy <= 1'b0;
			done <= 1'b0;
		end
		else if (ce)
		begin
			done <= 1'b0;
			if (start && !busy)
			begin
				if (waits == 2'h0)
					done <= 1'b1;
				else
				begin
					busy <= 1'b1;
					remaining <= waits;
				end
			end
			else if (busy)
			begin
				if (remaining == 2'h1)
				begin
					busy <= 1'b0;
					done <= 1'b1;
				end
				remaining <= remaining - 2'h1;
			end
		end
	end
endmodule // wait_timer

// *** rtl/mem_addr_decoder.v ***
// Memory address decoder with AXI4-Lite configuration registers
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "addr_decoder_map.vh"
module mem_addr_decoder
#(
	parameter ADDR_W = 24
)
(
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire boot_mode,
	input wire cpu_req,
	input wire [ADDR_W-1:0] cpu_addr,
	input wire cpu_byte,
	output reg [3:0] target_sel,
	output reg target_valid,
	output reg [ADDR_W-1:0] target_addr,
	output reg cpu_ready,
	output reg [15:0] cpu_const_data,
	output reg const_data_valid,
	output reg byte_violation,
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_DONE = 2'h2;

	reg [15:0] system_config_reg;
	reg [15:0] periph_bus_config_reg;
	reg [15:0] large_ram_base_select;
	reg [15:0] access_count;
	reg boot_latched;
	reg [1:0] state;
	reg [3:0] held_target;
	reg aw_held;
	reg w_held;
	reg [11:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg [3:0] next_target;
	reg [1:0] next_waits;
	wire global_periph_bus_enable;
	wire small_ext_ram_enable;
	wire large_ext_ram_enable;
	wire first_can_window_enable;
	wire second_can_window_enable;
	wire timer_done;
	wire timer_start;

	assign global_periph_bus_enable = system_config_reg[`SYSCFG_PERIPH_EN_BIT];
	assign small_ext_ram_enable = periph_bus_config_reg[`PBCFG_SMALL_RAM_BIT];
	assign large_ext_ram_enable = periph_bus_config_reg[`PBCFG_LARGE_RAM_BIT];
	assign first_can_window_enable = periph_bus_config_reg[`PBCFG_CAN1_BIT];
	assign second_can_window_enable = periph_bus_config_reg[`PBCFG_CAN2_BIT];

	function in_range;
		input [23:0] a;
		input [23:0] lo;
		input [23:0] hi;
		begin
			in_range = (a >= lo) && (a <= hi);
		end
	endfunction

	// Large RAM base select holds address bits 23:16; 64K region, image every 16K
	function large_hit;
		input [23:0] a;
		input [15:0] base_sel;
		begin
			large_hit = (a[23:16] == base_sel[7:0]) && (a[13] == 1'b0);
		end
	endfunction

	// Priority chain; the first match wins so only one target is ever selected
	always @*
	begin
		next_target = `TGT_EXT;
		next_waits = 2'h0;
		if (boot_latched && in_range(cpu_addr, `FLASH_LOW_BASE, `TEST_FLASH_LAST))
			next_target = `TGT_TEST_FLASH;
		else if (in_range(cpu_addr, `FLASH_LOW_BASE, `FLASH_LOW_LAST)
			|| in_range(cpu_addr, `FLASH_B4_BASE, `FLASH_B4_LAST)
			|| in_range(cpu_addr, `FLASH_B5_BASE, `FLASH_B5_LAST))
			next_target = `TGT_FLASH;
		else if (in_range(cpu_addr, `RSV_FLASH_BASE, `RSV_FLASH_LAST))
			next_target = `TGT_FLASH;
		else if (in_range(cpu_addr, `RSV_IBUS_BASE, `RSV_IBUS_LAST))
			next_target = `TGT_RSV_IBUS;
		else if (in_range(cpu_addr, `DUAL_PORT_INTERNAL_RAM_BASE, `DUAL_PORT_INTERNAL_RAM_LAST))
			next_target = `TGT_DUAL_PORT_INTERNAL_RAM;
		else if (in_range(cpu_addr, `SFR_BASE, `SFR_LAST)
			|| in_range(cpu_addr, `ESFR_BASE, `ESFR_LAST))
			next_target = `TGT_SFR;
		else if (global_periph_bus_enable && first_can_window_enable
			&& in_range(cpu_addr, `CAN1_BASE, `CAN1_LAST))
		begin
			next_target = `TGT_CAN1;
			next_waits = `WAIT_CAN;
		end
		else if (global_periph_bus_enable && second_can_window_enable
			&& in_range(cpu_addr, `CAN2_BASE, `CAN2_LAST))
		begin
			next_target = `TGT_CAN2;
			next_waits = `WAIT_CAN;
		end
		else if (global_periph_bus_enable && small_ext_ram_enable
			&& in_range(cpu_addr, `SMALL_RAM_BASE, `SMALL_RAM_LAST))
		begin
			next_target = `TGT_SMALL_RAM;
			next_waits = `WAIT_EXT_RAM;
		end
		else if (global_periph_bus_enable && large_ext_ram_enable
			&& large_hit(cpu_addr, large_ram_base_select))
		begin
			next_target = `TGT_LARGE_RAM;
			next_waits = `WAIT_EXT_RAM;
		end
	end
	// Disabled small/large RAM ranges fall through to TGT_EXT

	assign timer_start = (state == ST_IDLE) && cpu_req;

	wait_timer u_wait_timer
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.start(timer_start),
		.waits(next_waits),
		.done(timer_done)
	);

	// CPU access sequencing
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= ST_IDLE;
			held_target <= `TGT_EXT;
			target_sel <= `TGT_EXT;
			target_valid <= 1'b0;
			target_addr <= {ADDR_W{1'b0}};
			cpu_ready <= 1'b0;
			cpu_const_data <= 16'h0000;
			const_data_valid <= 1'b0;
			byte_violation <= 1'b0;
			access_count <= 16'h0000;
			boot_latched <= 1'b0;
		end
		else if (ce)
		begin
			cpu_ready <= 1'b0;
			const_data_valid <= 1'b0;
			boot_latched <= boot_mode;
			case (state)
				ST_IDLE:
				begin
					if (cpu_req)
					begin
						held_target <= next_target;
						target_sel <= next_target;
						target_valid <= 1'b1;
						target_addr <= cpu_addr;
						// Byte access is legal everywhere except CAN windows
						if (cpu_byte && (next_target == `TGT_CAN1
							|| next_target == `TGT_CAN2))
							byte_violation <= 1'b1;
						state <= ST_WAIT;
					end
				end
				ST_WAIT:
				begin
					if (timer_done)
					begin
						cpu_ready <= 1'b1;
						target_valid <= 1'b0;
						if (held_target == `TGT_RSV_IBUS)
						begin
							cpu_const_data <= `RSV_IBUS_VALUE;
							const_data_valid <= 1'b1;
						end
						access_count <= access_count + 16'h0001;
						state <= ST_DONE;
					end
				end
				ST_DONE:
					state <= ST_IDLE;
				default:
					state <= ST_IDLE;
			endcase
		end
	end
	// Bit addressing never reaches extension RAM; no bit port exists

	// AXI4-Lite write path; address and data may arrive in either order
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= 12'h000;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			system_config_reg <= `RST_SYSTEM_CONFIG;
			periph_bus_config_reg <= `RST_PERIPH_BUS_CONFIG;
			large_ram_base_select <= `RST_LARGE_RAM_BASE;
		end
		else if (ce)
		begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
			s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (aw_held && w_held && !s_axi_bvalid)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
				case (aw_addr_q)
					`REG_SYSTEM_CONFIG:
					begin
						if (w_strb_q[0])
							system_config_reg[7:0] <= w_data_q[7:0];
						if (w_strb_q[1])
							system_config_reg[15:8] <= w_data_q[15:8];
					end
					`REG_PERIPH_BUS_CONFIG:
					begin
						if (w_strb_q[0])
							periph_bus_config_reg[7:0] <= w_data_q[7:0];
						if (w_strb_q[1])
							periph_bus_config_reg[15:8] <= w_data_q[15:8];
					end
					`REG_LARGE_RAM_BASE:
					begin
						if (w_strb_q[0])
							large_ram_base_select[7:0] <= w_data_q[7:0];
						if (w_strb_q[1])
							large_ram_base_select[15:8] <= w_data_q[15:8];
					end
					`REG_MODE, `REG_STATUS, `REG_ACCESS_COUNT:
						s_axi_bresp <= 2'h0;
					default:
						s_axi_bresp <= 2'h2;
				endcase
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// AXI4-Lite read path
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end
		else if (ce)
		begin
			s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				case (s_axi_araddr)
					`REG_SYSTEM_CONFIG:
						s_axi_rdata <= {16'h0000, system_config_reg};
					`REG_PERIPH_BUS_CONFIG:
						s_axi_rdata <= {16'h0000, periph_bus_config_reg};
					`REG_LARGE_RAM_BASE:
						s_axi_rdata <= {16'h0000, large_ram_base_select};
					`REG_MODE:
						s_axi_rdata <= {31'h00000000, boot_latched};
					`REG_STATUS:
						s_axi_rdata <= {24'h000000, byte_violation, state, target_valid,
							held_target};
					`REG_ACCESS_COUNT:
						s_axi_rdata <= {16'h0000, access_count};
					default:
					begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= 2'h2;
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // mem_addr_decoder

// *** dv/mem_addr_decoder_monitor.sv ***
// Checker for the address decoder's CPU-side ports
`timescale 1ns/1ps
`include "addr_decoder_map.vh"
module mem_addr_decoder_monitor
#(
	parameter ADDR_W = 24
)
(
	input wire aclk,
	input wire aresetn,
	input wire cpu_byte,
	input wire [ADDR_W-1:0] cpu_addr,
	input wire [3:0] target_sel,
	input wire target_valid,
	input wire [ADDR_W-1:0] target_addr,
	input wire cpu_ready,
	input wire [15:0] cpu_const_data,
	input wire const_data_valid,
	input wire byte_violation
);
	wire is_can = (target_sel == `TGT_CAN1) || (target_sel == `TGT_CAN2);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence no_wait_s;
		!cpu_ready ##1 cpu_ready;
	endsequence
	sequence can_wait_s;
		!cpu_ready [*3] ##1 cpu_ready;
	endsequence
	no_wait_done_a: assert property ($rose(target_valid) && !is_can
		|-> no_wait_s)
		else $error("zero-wait access not done in one cycle");
	can_waits_a: assert property ($rose(target_valid) && is_can
		|-> can_wait_s)
		else $error("window access without two waits");
	ready_pulse_a: assert property (cpu_ready |=> !cpu_ready)
		else $error("ready longer than one cycle");
	const_value_a: assert property (const_data_valid
		|-> cpu_ready && cpu_const_data == 16'h009b && target_sel == `TGT_RSV_IBUS)
		else $error("bad constant answer");
	rsv_const_a: assert property (cpu_ready && target_sel == `TGT_RSV_IBUS
		|-> const_data_valid)
		else $error("reserved area gave no constant");
	addr_capture_a: assert property ($rose(target_valid)
		|-> target_addr == $past(cpu_addr))
		else $error("address not captured");
	sel_stable_a: assert property (target_valid && !$rose(target_valid)
		|-> $stable(target_sel))
		else $error("target changed mid access");
	test_flash_a: assert property (target_valid && target_sel == `TGT_TEST_FLASH
		|-> target_addr <= 24'h001fff)
		else $error("test flash outside its block");
	flash_hi_a: assert property ($rose(target_valid) && target_addr >= 24'h018000
		&& target_addr <= 24'h02ffff |-> target_sel == `TGT_FLASH)
		else $error("upper flash blocks not decoded");
	byte_flag_a: assert property ($rose(target_valid) && is_can && cpu_byte
		|-> ##[0:3] byte_violation)
		else $error("byte window access not flagged");
	flag_sticky_a: assert property (byte_violation |=> byte_violation)
		else $error("violation flag dropped");
endmodule // mem_addr_decoder_monitor
bind mem_addr_decoder mem_addr_decoder_monitor #(.ADDR_W(ADDR_W)) u_mon (.aclk(aclk),
	.aresetn(aresetn), .cpu_byte(cpu_byte), .cpu_addr(cpu_addr), .target_sel(target_sel),
	.target_valid(target_valid), .target_addr(target_addr), .cpu_ready(cpu_ready),
	.cpu_const_data(cpu_const_data), .const_data_valid(const_data_valid),
	.byte_violation(byte_violation));

// *** dv/cpu_model.sv ***
// CPU core model that issues one access per go pulse
`timescale 1ns/1ps
module cpu_model
(
	input wire aclk,
	input wire aresetn,
	input wire go,
	input wire [23:0] addr,
	input wire byte_acc,
	input wire cpu_ready,
	output reg cpu_req,
	output reg [23:0] cpu_addr,
	output reg cpu_byte,
	output reg done
);
	always @(posedge aclk)
	begin
		done <= 1'b0;
		if (!aresetn)
		begin
			cpu_req <= 1'b0;
			cpu_addr <= 24'h000000;
			cpu_byte <= 1'b0;
		end
		else if (cpu_req && cpu_ready)
		begin
			// Released address flips so a stale value is never mistaken for a hold
			cpu_req <= 1'b0;
			cpu_addr <= ~cpu_addr;
			done <= 1'b1;
		end
		else if (go && !cpu_req)
		begin
			cpu_req <= 1'b1;
			cpu_addr <= addr;
			cpu_byte <= byte_acc;
		end
	end
endmodule // cpu_model

// *** dv/onchip_memory_address_decoder_test.sv ***
// Testbench for the memory address decoder
`timescale 1ns/1ps
`include "addr_decoder_map.vh"
module onchip_memory_address_decoder_test;
	reg aclk = 1'b0;
	reg aresetn = 1'b0;
	reg ce = 1'b1;
	reg boot_mode = 1'b0;
	reg go = 1'b0;
	reg bsel = 1'b0;
	reg [23:0] addr = 24'h000000;
	reg [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	reg [31:0] s_axi_wdata = 32'h0;
	reg [3:0] s_axi_wstrb = 4'hf;
	reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire cpu_req, cpu_byte, target_valid, cpu_ready, const_data_valid, byte_violation, done;
	wire [23:0] cpu_addr, target_addr;
	wire [3:0] target_sel;
	wire [15:0] cpu_const_data;
	integer mismatches = 0;
	integer n_compared = 0;
	integer cycles = 0;
	always #5 aclk = ~aclk;
	cpu_model cpu (.aclk(aclk), .aresetn(aresetn), .go(go), .addr(addr), .byte_acc(bsel),
		.cpu_ready(cpu_ready), .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_byte(cpu_byte),
		.done(done));
	mem_addr_decoder dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .boot_mode(boot_mode),
		.cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_byte(cpu_byte), .target_sel(target_sel),
		.target_valid(target_valid), .target_addr(target_addr), .cpu_ready(cpu_ready),
		.cpu_const_data(cpu_const_data), .const_data_valid(const_data_valid),
		.byte_violation(byte_violation), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));
	task conclude;
	begin
		if (mismatches == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
	begin
		n_compared = n_compared + 1;
		if (got !== exp)
		begin
			mismatches = mismatches + 1;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task axw(input [11:0] a, input [31:0] d, input [1:0] er);
	begin
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
	end
	endtask
	task axr(input [11:0] a, input [31:0] ed, input [1:0] er);
	begin
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, ed);
		chk(s_axi_rresp, er);
	end
	endtask
	task acc(input [23:0] a, input b, input [3:0] exp);
	begin
		@(posedge aclk);
		go <= 1'b1;
		addr <= a;
		bsel <= b;
		@(posedge aclk);
		go <= 1'b0;
		@(posedge aclk);
		while (done !== 1'b1)
			@(posedge aclk);
		chk(target_sel, exp);
	end
	endtask
	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			mismatches = mismatches + 1;
			conclude;
		end
	end
	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		axr(12'h008, 32'h9, 2'h0);
		axr(12'h004, 32'h0, 2'h0);
		axr(12'h100, 32'h0, 2'h2);
		axw(12'h00c, 32'h1, 2'h0);
		axr(12'h00c, 32'h0, 2'h0);
		acc(24'h000000, 1'b0, `TGT_FLASH);
		acc(24'h007fff, 1'b1, `TGT_FLASH);
		acc(24'h008000, 1'b0, `TGT_EXT);
		acc(24'h018000, 1'b0, `TGT_FLASH);
		acc(24'h02ffff, 1'b0, `TGT_FLASH);
		acc(24'h04ffff, 1'b0, `TGT_FLASH);
		acc(24'h050000, 1'b0, `TGT_RSV_IBUS);
		acc(24'h07ffff, 1'b1, `TGT_RSV_IBUS);
		chk(cpu_const_data, `RSV_IBUS_VALUE);
		acc(24'h00f600, 1'b1, `TGT_DUAL_PORT_INTERNAL_RAM);
		acc(24'h00fe00, 1'b0, `TGT_SFR);
		acc(24'h00f1ff, 1'b0, `TGT_SFR);
		acc(24'h090000, 1'b0, `TGT_EXT);
		axw(12'h004, 32'hf, 2'h0);
		acc(24'h00e000, 1'b0, `TGT_EXT);
		acc(24'h00ef00, 1'b0, `TGT_EXT);
		acc(24'h094000, 1'b0, `TGT_EXT);
		axw(12'h000, 32'h4, 2'h0);
		acc(24'h00e000, 1'b1, `TGT_SMALL_RAM);
		acc(24'h00e7ff, 1'b0, `TGT_SMALL_RAM);
		acc(24'h00e800, 1'b0, `TGT_EXT);
		acc(24'h00efff, 1'b0, `TGT_CAN1);
		acc(24'h00ee00, 1'b0, `TGT_CAN2);
		acc(24'h090000, 1'b1, `TGT_LARGE_RAM);
		acc(24'h091fff, 1'b0, `TGT_LARGE_RAM);
		acc(24'h094000, 1'b0, `TGT_LARGE_RAM);
		acc(24'h092000, 1'b0, `TGT_EXT);
		chk(byte_violation, 1'b0);
		acc(24'h00ef00, 1'b1, `TGT_CAN1);
		chk(byte_violation, 1'b1);
		axw(12'h004, 32'h8, 2'h0);
		acc(24'h00e000, 1'b0, `TGT_EXT);
		acc(24'h00ee00, 1'b0, `TGT_EXT);
		axw(12'h008, 32'ha, 2'h0);
		acc(24'h0a0000, 1'b0, `TGT_LARGE_RAM);
		acc(24'h090000, 1'b0, `TGT_EXT);
		boot_mode <= 1'b1;
		acc(24'h000000, 1'b0, `TGT_TEST_FLASH);
		acc(24'h001fff, 1'b1, `TGT_TEST_FLASH);
		acc(24'h002000, 1'b0, `TGT_FLASH);
		// Frozen decoder must leave a pending request untouched until ce returns
		@(posedge aclk);
		ce <= 1'b0;
		go <= 1'b1;
		addr <= 24'h00f600;
		bsel <= 1'b0;
		@(posedge aclk);
		go <= 1'b0;
		repeat (4) @(posedge aclk);
		chk(target_sel, `TGT_FLASH);
		ce <= 1'b1;
		while (done !== 1'b1)
			@(posedge aclk);
		chk(target_sel, `TGT_DUAL_PORT_INTERNAL_RAM);
		axr(12'h00c, 32'h1, 2'h0);
		// Thirty-three accesses were issued above, one completion each
		axr(12'h014, 32'h21, 2'h0);
		conclude;
	end
endmodule // onchip_memory_address_decoder_test
